// >>> hdl/sdr_regs.svh
// command codes, mode fields and timing constants of the sdram bank core
`ifndef SDR_REGS_SVH
`define SDR_REGS_SVH

// {ras_n, cas_n, we_n} command codes
`define SDR_CMD_MRS     3'h0
`define SDR_CMD_REF     3'h1
`define SDR_CMD_PRE     3'h2
`define SDR_CMD_ACT     3'h3
`define SDR_CMD_WRITE   3'h4
`define SDR_CMD_READ    3'h5
`define SDR_CMD_BST     3'h6
`define SDR_CMD_NOP     3'h7

// mode word fields, taken from the address lines on a mode load
`define SDR_MODE_W      4
`define SDR_MODE_BL     2:0
`define SDR_MODE_BT     3
`define SDR_MODE_RST    4'h0
`define SDR_BL_1        3'h0
`define SDR_BL_2        3'h1
`define SDR_BL_4        3'h2
`define SDR_BL_8        3'h3
`define SDR_BL_FULL     3'h7

// address bit that selects precharge scope / auto precharge
`define SDR_SCOPE_BIT   10

// timing, in ns; counter width in bits
`define SDR_CLK_NS      40
`define SDR_T_RP_NS     20
`define SDR_T_RFC_NS    60
`define SDR_CNT_W       4

`endif

// >>> hdl/sdr_pkg.sv
// types shared by the sdram bank core
package sdr_pkg;
   typedef enum logic [1:0] {
      SDR_ST_RUN,
      SDR_ST_REFRESH,
      SDR_ST_PWRDN
   } sdr_state_t;
endpackage

// >>> hdl/sdr_bank_core.sv
// sdram device core: command decode, four banks, burst engine, array
// Functional notes
// - all command, address and write data sampled on rising clock edge only.
// - four banks of 8192 rows; 512x16 or 1024x8 columns per row.
// - activate takes bank from bank select, row from thirteen address lines.
// - read/write takes start column from low nine or ten address lines.
// - burst length 1, 2, 4, 8 or full page; burst terminate cuts short.
// - device generates following columns in programmed order, one word per clock.
// - auto precharge closes the row, self timed, after the burst ends.
// - one bank may precharge while another bank is accessed.
// - new read or write during a burst redirects it on any cycle.
// - auto refresh operation and a power-down state are provided.
// - wide variant masks lower and upper bytes separately; narrow has one mask.
// - scope bit high precharges all banks; with read/write requests auto precharge.
// - chip select high ignores commands and keeps state.
// - high byte mask blocks write; on read it floats that byte.
// - edge valid only while clock gate input high; low means power-down or suspend.
`timescale 1ns/1ns
`include "sdr_regs.svh"
module sdr_bank_core #(
   parameter int DATA_W = 16,
   parameter int COL_W  = 9,
   parameter int ROW_W  = 13
) (
   input  wire logic                ref_clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                cke_i,
   input  wire logic                cs_n_i,
   input  wire logic                ras_n_i,
   input  wire logic                cas_n_i,
   input  wire logic                we_n_i,
   input  wire logic [1:0]          bank_select_lines_i,
   input  wire logic [ROW_W-1:0]    row_address_lines_i,
   input  wire logic                lower_byte_mask_i,
   input  wire logic                upper_byte_mask_i,
   input  wire logic [DATA_W-1:0]   data_lines_i,
   output logic      [DATA_W-1:0]   data_lines_o,
   output logic      [DATA_W/8-1:0] data_lines_oe_o,
   output logic                     power_down_o,
   output logic                     refresh_busy_o
);
   localparam int MASK_W = DATA_W / 8;
   localparam int IDX_W  = 2 + ROW_W + COL_W;
   localparam int DEPTH  = 1 << IDX_W;
   localparam int RP_RAW = (`SDR_T_RP_NS + `SDR_CLK_NS - 1) / `SDR_CLK_NS;
   localparam int RF_RAW = (`SDR_T_RFC_NS + `SDR_CLK_NS - 1) / `SDR_CLK_NS;
   localparam logic [`SDR_CNT_W-1:0] RP_CYC = `SDR_CNT_W'((RP_RAW < 1) ? 1 : RP_RAW);
   localparam logic [`SDR_CNT_W-1:0] RF_CYC = `SDR_CNT_W'((RF_RAW < 1) ? 1 : RF_RAW);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   sdr_pkg::sdr_state_t          state_r, state_nxt;
   logic [`SDR_MODE_W-1:0]       mode_r, mode_nxt;
   logic [3:0]                   open_r, open_nxt;
   logic [ROW_W-1:0]             row_r [4];
   logic [ROW_W-1:0]             row_nxt [4];
   logic [`SDR_CNT_W-1:0]        pcnt_r [4];
   logic [`SDR_CNT_W-1:0]        pcnt_nxt [4];
   logic [`SDR_CNT_W-1:0]        rcnt_r, rcnt_nxt;
   logic                         bact_r, bact_nxt;
   logic                         bwr_r, bwr_nxt;
   logic                         bap_r, bap_nxt;
   logic [1:0]                   bbank_r, bbank_nxt;
   logic [COL_W-1:0]             bcol_r, bcol_nxt;
   logic [COL_W-1:0]             bcnt_r, bcnt_nxt;
   logic [DATA_W-1:0]            data_r, data_nxt;
   logic [MASK_W-1:0]            oe_r, oe_nxt;
   logic [1:0]                   stat_r, stat_nxt;
   // access of this edge
   logic                         acc_en;
   logic                         acc_wr;
   logic [IDX_W-1:0]             acc_idx;
   logic [MASK_W-1:0]            msk;
   logic [COL_W-1:0]             bl_m;
   logic                         bl_full;
   logic [2:0]                   cmd;
   logic                         cmd_ok;
   logic                         ap_bit;
   logic [COL_W-1:0]             col_in;
   logic [COL_W-1:0]             seq_col;
   logic [1:0]                   cbank;
   wire logic [DATA_W-1:0]       rd_word;
   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      mode_nxt  = mode_r;
      open_nxt  = open_r;
      row_nxt   = row_r;
      pcnt_nxt  = pcnt_r;
      rcnt_nxt  = rcnt_r;
      bact_nxt  = bact_r;
      bwr_nxt   = bwr_r;
      bap_nxt   = bap_r;
      bbank_nxt = bbank_r;
      bcol_nxt  = bcol_r;
      bcnt_nxt  = bcnt_r;
      data_nxt  = data_r;
      oe_nxt    = '0;
      acc_en    = 1'b0;
      acc_wr    = 1'b0;
      acc_idx   = '0;
      seq_col   = '0;
      msk       = MASK_W'({upper_byte_mask_i, lower_byte_mask_i});
      cmd       = {ras_n_i, cas_n_i, we_n_i};
      cbank     = bank_select_lines_i;
      ap_bit    = row_address_lines_i[`SDR_SCOPE_BIT];
      col_in    = row_address_lines_i[COL_W-1:0];
      bl_full   = (mode_r[`SDR_MODE_BL] == `SDR_BL_FULL);
      case (mode_r[`SDR_MODE_BL])
         `SDR_BL_2: bl_m = COL_W'(1);
         `SDR_BL_4: bl_m = COL_W'(3);
         `SDR_BL_8: bl_m = COL_W'(7);
         `SDR_BL_FULL: bl_m = '1;
         default: bl_m = '0;
      endcase
      // self-timed precharge runs per bank, whatever else happens
      for (int b = 0; b < 4; b++) begin
         if (pcnt_r[b] != '0) begin
            pcnt_nxt[b] = pcnt_r[b] - `SDR_CNT_W'(1);
         end
      end
      // commands decoded only with chip select low; and clock gate high
      cmd_ok = cke_i && !cs_n_i && (state_r == sdr_pkg::SDR_ST_RUN);
      case (state_r)
         sdr_pkg::SDR_ST_RUN: begin
            if (bact_r && cke_i) begin
               seq_col  = (bcol_r & ~bl_m) | (bl_m & ((mode_r[`SDR_MODE_BT] && !bl_full) ?
                          (bcol_r ^ bcnt_r) : (bcol_r + bcnt_r)));
               acc_en   = 1'b1;
               acc_wr   = bwr_r;
               acc_idx  = {bbank_r, row_r[bbank_r], seq_col};
               bcnt_nxt = bcnt_r + COL_W'(1);
               if (!bl_full && bcnt_r == bl_m) begin
                  bact_nxt = 1'b0;
                  if (bap_r) begin
                     open_nxt[bbank_r] = 1'b0;
                     pcnt_nxt[bbank_r] = RP_CYC;
                  end
               end
            end
            if (cmd_ok) begin
               case (cmd)
                  `SDR_CMD_ACT: begin
                     if (!open_r[cbank] && pcnt_r[cbank] == '0) begin
                        open_nxt[cbank] = 1'b1;
                        row_nxt[cbank]  = row_address_lines_i;
                     end
                  end
                  `SDR_CMD_READ, `SDR_CMD_WRITE: begin
                     // redirect; start column from low lines
                     if (open_r[cbank]) begin
                        acc_en    = 1'b1;
                        acc_wr    = (cmd == `SDR_CMD_WRITE);
                        acc_idx   = {cbank, row_r[cbank], col_in};
                        bwr_nxt   = acc_wr;
                        bbank_nxt = cbank;
                        bcol_nxt  = col_in;
                        bcnt_nxt  = COL_W'(1);
                        // scope bit asks for auto precharge
                        bap_nxt   = ap_bit;
                        bact_nxt  = bl_full || (bl_m != '0);
                        if (!bact_nxt && ap_bit) begin
                           open_nxt[cbank] = 1'b0;
                           pcnt_nxt[cbank] = RP_CYC;
                        end
                     end
                  end
                  `SDR_CMD_BST: begin
                     bact_nxt = 1'b0;
                  end
                  `SDR_CMD_PRE: begin
                     for (int b = 0; b < 4; b++) begin
                        if (open_r[b] && (ap_bit || cbank == 2'(b))) begin
                           open_nxt[b] = 1'b0;
                           pcnt_nxt[b] = RP_CYC;
                           if (bbank_r == 2'(b)) begin
                              bact_nxt = 1'b0;
                           end
                        end
                     end
                  end
                  `SDR_CMD_REF: begin
                     // auto refresh needs all banks idle
                     if (open_r == '0 && !bact_r) begin
                        state_nxt = sdr_pkg::SDR_ST_REFRESH;
                        rcnt_nxt  = RF_CYC;
                     end
                  end
                  `SDR_CMD_MRS: begin
                     if (open_r == '0 && !bact_r) begin
                        mode_nxt = row_address_lines_i[`SDR_MODE_W-1:0];
                     end
                  end
                  default: ;
               endcase
            end
            // clock gate low while idle enters power-down
            if (!cke_i && !bact_r) begin
               state_nxt = sdr_pkg::SDR_ST_PWRDN;
            end
         end
         sdr_pkg::SDR_ST_REFRESH: begin
            rcnt_nxt = rcnt_r - `SDR_CNT_W'(1);
            if (rcnt_r <= `SDR_CNT_W'(1)) begin
               state_nxt = sdr_pkg::SDR_ST_RUN;
            end
         end
         sdr_pkg::SDR_ST_PWRDN: begin
            if (cke_i) begin
               state_nxt = sdr_pkg::SDR_ST_RUN;
            end
         end
         default: begin
            state_nxt = sdr_pkg::SDR_ST_RUN;
         end
      endcase
      if (acc_en && !acc_wr) begin
         data_nxt = rd_word;
         oe_nxt   = ~msk;
      end
      stat_nxt = {state_nxt == sdr_pkg::SDR_ST_REFRESH, state_nxt == sdr_pkg::SDR_ST_PWRDN};
   end
   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   // rising edge only
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_r <= sdr_pkg::SDR_ST_RUN;
         mode_r  <= `SDR_MODE_RST;
         open_r  <= '0;
         rcnt_r  <= '0;
         bact_r  <= 1'b0;
         bwr_r   <= 1'b0;
         bap_r   <= 1'b0;
         bbank_r <= '0;
         bcol_r  <= '0;
         bcnt_r  <= '0;
         data_r  <= '0;
         oe_r    <= '0;
         stat_r  <= '0;
         row_r   <= '{default: '0};
         pcnt_r  <= '{default: '0};
      end else begin
         state_r <= state_nxt;
         mode_r  <= mode_nxt;
         open_r  <= open_nxt;
         rcnt_r  <= rcnt_nxt;
         bact_r  <= bact_nxt;
         bwr_r   <= bwr_nxt;
         bap_r   <= bap_nxt;
         bbank_r <= bbank_nxt;
         bcol_r  <= bcol_nxt;
         bcnt_r  <= bcnt_nxt;
         data_r  <= data_nxt;
         oe_r    <= oe_nxt;
         row_r   <= row_nxt;
         pcnt_r  <= pcnt_nxt;
         stat_r  <= stat_nxt;
      end
   end
   // -----------------------------------------------------------------
   // array, one storage lane per byte
   // -----------------------------------------------------------------
   // four banks of rows and columns
   for (genvar g = 0; g < MASK_W; g++) begin : g_lane
      logic [7:0] lane_r [DEPTH];
      assign rd_word[g*8 +: 8] = lane_r[acc_idx];
      always_ff @(posedge ref_clk_i) begin
         if (acc_en && acc_wr && !msk[g]) begin
            lane_r[acc_idx] <= data_lines_i[g*8 +: 8];
         end
      end
   end
   assign data_lines_o    = data_r;
   assign data_lines_oe_o = oe_r;
   assign power_down_o    = stat_r[0];
   assign refresh_busy_o  = stat_r[1];
endmodule

// >>> verification/sdr_bank_chk.sv
// port assertions for the sdram bank core
`timescale 1ns/1ns
`include "sdr_regs.svh"
module sdr_bank_chk #(
   parameter int DATA_W = 16,
   parameter int COL_W  = 9,
   parameter int ROW_W  = 13
) (
   input wire logic                ref_clk_i,
   input wire logic                rst_n_i,
   input wire logic                cke_i,
   input wire logic                cs_n_i,
   input wire logic                ras_n_i,
   input wire logic                cas_n_i,
   input wire logic                we_n_i,
   input wire logic [1:0]          bank_select_lines_i,
   input wire logic [ROW_W-1:0]    row_address_lines_i,
   input wire logic                lower_byte_mask_i,
   input wire logic                upper_byte_mask_i,
   input wire logic [DATA_W-1:0]   data_lines_i,
   input wire logic [DATA_W-1:0]   data_lines_o,
   input wire logic [DATA_W/8-1:0] data_lines_oe_o,
   input wire logic                power_down_o,
   input wire logic                refresh_busy_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   wire logic [2:0] cmd_w = {ras_n_i, cas_n_i, we_n_i};
   cs_ignore_a: assert property (cs_n_i && cke_i && $past(cke_i) && data_lines_oe_o == '0
      && !$past(lower_byte_mask_i) && !$past(upper_byte_mask_i) |=> data_lines_oe_o == '0)
      else $error("read began while deselected");
   ref_len_a: assert property ($rose(refresh_busy_o) |-> refresh_busy_o [*2] ##1 !refresh_busy_o)
      else $error("refresh busy length wrong");
   ref_cause_a: assert property ($rose(refresh_busy_o)
      |-> !$past(cs_n_i) && $past(cke_i) && $past(cmd_w) == `SDR_CMD_REF)
      else $error("refresh without command");
   pd_enter_a: assert property ($rose(power_down_o) |-> !$past(cke_i))
      else $error("power-down without clock gate low");
   pd_exit_a: assert property (power_down_o && cke_i |=> !power_down_o)
      else $error("power-down not left");
   cke_freeze_a: assert property (!cke_i |=> data_lines_oe_o == '0)
      else $error("output driven on gated edge");
   lo_mask_a: assert property (data_lines_oe_o[0] |-> !$past(lower_byte_mask_i))
      else $error("lower byte driven while masked");
   hi_mask_a: assert property (data_lines_oe_o[DATA_W/8-1] |-> !$past(upper_byte_mask_i))
      else $error("upper byte driven while masked");
endmodule

// >>> verification/sdr_ctl_model.sv
// controller model driving the sdram command, address and data pins
`timescale 1ns/1ns
module sdr_ctl_model #(
   parameter int ROW_W = 13
) (
   input  wire logic             clk_i,
   input  wire logic [15:0]      q_i,
   input  wire logic [1:0]       oe_i,
   output logic                  cke_o,
   output logic                  cs_n_o,
   output logic [2:0]            cmd_o,
   output logic [1:0]            ba_o,
   output logic [ROW_W-1:0]      a_o,
   output logic [1:0]            dm_o,
   output logic [15:0]           dq_o
);
   logic [15:0] drv_r;
   logic [15:0] last_r = '0;
   logic        wr_r;
   initial begin
      {cke_o, cs_n_o, cmd_o, ba_o, a_o, dm_o, wr_r, drv_r} = '1;
   end
   // undriven bytes flip every cycle
   always_comb begin
      for (int g = 0; g < 2; g++) begin
         dq_o[g*8+:8] = oe_i[g] ? q_i[g*8+:8] : (wr_r ? drv_r[g*8+:8] : ~last_r[g*8+:8]);
      end
   end
   always @(posedge clk_i) last_r <= dq_o;
   // pins move together after rising edge
   task automatic issue(input logic [4:0] cc, input logic [1:0] ba, input logic [ROW_W-1:0] a,
                        input logic [1:0] m, input logic w, input logic [15:0] d);
      @(posedge clk_i);
      {cke_o, cs_n_o, cmd_o} <= cc;
      ba_o <= ba;
      a_o <= a;
      dm_o <= m;
      wr_r <= w;
      drv_r <= d;
   endtask
endmodule

// >>> verification/tb.sv
// self-checking bench for the sdram bank core
`timescale 1ns/1ns
`include "sdr_regs.svh"
module tb;
   localparam int DATA_W = 16, COL_W = 4, ROW_W = 11;
   localparam logic [2:0] c_mrs = `SDR_CMD_MRS, c_ref = `SDR_CMD_REF, c_pre = `SDR_CMD_PRE;
   localparam logic [2:0] c_act = `SDR_CMD_ACT, c_wr = `SDR_CMD_WRITE, c_rd = `SDR_CMD_READ;
   localparam logic [2:0] c_bst = `SDR_CMD_BST, c_nop = `SDR_CMD_NOP;
   logic             ref_clk_i = 1'b0, rst_n_i = 1'b0, cke_v = 1'b1, csn_v = 1'b0;
   logic             cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, lower_byte_mask_i;
   logic             upper_byte_mask_i, power_down_o, refresh_busy_o;
   logic [1:0]       bank_select_lines_i, data_lines_oe_o, bk = 2'h1;
   logic [ROW_W-1:0] row_address_lines_i;
   logic [15:0]      data_lines_i, data_lines_o, mem [16];
   int               error_cnt = 0, cmp_count = 0;
   always #20 ref_clk_i = ~ref_clk_i;
   sdr_bank_core #(.DATA_W(DATA_W), .COL_W(COL_W), .ROW_W(ROW_W)) dut (.ref_clk_i, .rst_n_i,
      .cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .bank_select_lines_i, .row_address_lines_i,
      .lower_byte_mask_i, .upper_byte_mask_i, .data_lines_i, .data_lines_o, .data_lines_oe_o,
      .power_down_o, .refresh_busy_o);
   sdr_ctl_model #(.ROW_W(ROW_W)) ctl (.clk_i(ref_clk_i), .q_i(data_lines_o),
      .oe_i(data_lines_oe_o), .cke_o(cke_i), .cs_n_o(cs_n_i), .cmd_o({ras_n_i, cas_n_i, we_n_i}),
      .ba_o(bank_select_lines_i), .a_o(row_address_lines_i),
      .dm_o({upper_byte_mask_i, lower_byte_mask_i}), .dq_o(data_lines_i));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic op(input logic [2:0] c, input logic [ROW_W-1:0] a = '0,
                     input logic [15:0] d = '0, input logic [1:0] m = '0, input logic w = 0);
      ctl.issue({cke_v, csn_v, c}, bk, a, m, w, d);
   endtask
   function automatic logic [3:0] colx(input logic [3:0] s, input int n, input int bl,
                                       input logic il);
      logic [3:0] k;
      k = 4'(bl - 1);
      return (s & ~k) | ((il ? s ^ 4'(n) : s + 4'(n)) & k);
   endfunction
   task automatic wr(input logic [3:0] col, input int bl, input logic [15:0] d0,
                     input logic [1:0] mw);
      logic [15:0] d;
      logic [1:0]  m;
      logic [3:0]  x;
      for (int n = 0; n < bl; n++) begin
         d = d0 + 16'(n);
         m = (n == 1) ? mw : 2'h0;
         x = colx(col, n, bl, 1'b0);
         op(n == 0 ? c_wr : c_nop, {7'h0, col}, d, m, 1'b1);
         mem[x] = {m[1] ? mem[x][15:8] : d[15:8], m[0] ? mem[x][7:0] : d[7:0]};
      end
      op(c_nop);
   endtask
   task automatic rd(input logic [3:0] col, input int bl, input logic il, input logic ok,
                     input logic ap = 1'b0);
      op(c_rd, {ap, 6'h0, col});
      for (int n = 0; n < bl; n++) begin
         op(n == bl - 1 && bl == 16 ? c_bst : c_nop);
         #1;
         chk(data_lines_oe_o, ok ? 2'h3 : 2'h0);
         if (ok) chk(data_lines_o, mem[colx(col, n, bl, il)]);
      end
      op(c_nop);
      if (bl == 16) op(c_nop);
      #1;
      chk(data_lines_oe_o, 2'h0);
   endtask
   task automatic setmode(input logic [3:0] code);
      op(c_pre, 11'h400);
      op(c_nop);
      op(c_nop);
      op(c_mrs, {7'h0, code});
      op(c_act, 11'h005);
   endtask
   task automatic s_lengths();
      setmode(4'h3);
      wr(4'h0, 8, 16'h1200, 2'h0);
      wr(4'h8, 8, 16'h3400, 2'h0);
      for (int i = 0; i < 5; i++) begin
         setmode(i == 4 ? 4'h7 : 4'(i));
         rd(4'h6, i == 4 ? 16 : 1 << i, 1'b0, 1'b1);
      end
      setmode(4'hb);
      rd(4'h5, 8, 1'b1, 1'b1);
   endtask
   task automatic s_mask();
      setmode(4'h2);
      wr(4'h4, 4, 16'hc0c0, 2'h2);
      op(c_rd, 11'h004);
      rd(4'h6, 4, 1'b0, 1'b1);
      op(c_rd, 11'h004, 16'h0, 2'h1);
      op(c_nop);
      #1;
      chk(data_lines_oe_o, 2'h2);
      chk(data_lines_o[15:8], mem[4][15:8]);
      repeat (4) op(c_nop);
   endtask
   task automatic s_stop();
      op(c_rd, 11'h004);
      op(c_nop);
      op(c_bst);
      repeat (2) op(c_nop);
      #1;
      chk(data_lines_oe_o, 2'h0);
      csn_v = 1'b1;
      op(c_rd, 11'h004);
      csn_v = 1'b0;
      op(c_nop);
      #1;
      chk(data_lines_oe_o, 2'h0);
   endtask
   task automatic s_close();
      rd(4'h4, 4, 1'b0, 1'b1, 1'b1);
      rd(4'h4, 4, 1'b0, 1'b0);
      op(c_act, 11'h005);
      bk = 2'h2;
      op(c_act, 11'h005);
      op(c_pre, 11'h000);
      bk = 2'h1;
      rd(4'h4, 4, 1'b0, 1'b1);
      op(c_pre, 11'h400);
      op(c_nop);
      rd(4'h4, 4, 1'b0, 1'b0);
      op(c_ref);
      op(c_nop);
      #1;
      chk(refresh_busy_o, 1'b1);
      repeat (2) op(c_nop);
      #1;
      chk(refresh_busy_o, 1'b0);
   endtask
   task automatic s_power();
      setmode(4'h2);
      op(c_rd, 11'h004);
      op(c_nop);
      cke_v = 1'b0;
      op(c_nop);
      cke_v = 1'b1;
      op(c_nop);
      #1;
      chk(data_lines_oe_o, 2'h0);
      op(c_nop);
      #1;
      chk(data_lines_o, mem[6]);
      repeat (3) op(c_nop);
      cke_v = 1'b0;
      repeat (2) op(c_nop);
      #1;
      chk(power_down_o, 1'b1);
      cke_v = 1'b1;
      repeat (2) op(c_nop);
      #1;
      chk(power_down_o, 1'b0);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      s_lengths();
      s_mask();
      s_stop();
      s_close();
      s_power();
      stop_test();
   end
endmodule
bind sdr_bank_core sdr_bank_chk #(.DATA_W(DATA_W), .COL_W(COL_W), .ROW_W(ROW_W)) chk_u (
   .ref_clk_i, .rst_n_i, .cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .bank_select_lines_i,
   .row_address_lines_i, .lower_byte_mask_i, .upper_byte_mask_i, .data_lines_i, .data_lines_o,
   .data_lines_oe_o, .power_down_o, .refresh_busy_o);
